// ---- fu_uart.sv ----
// Serial port with 15-byte transmit and receive queues.
// Assumes a register master that never waits and a line input
// already synchronous to clk_sys.
//
// Contract
// - Separate 15-byte TX and RX FIFOs, each with its own threshold.
// - Bit timing comes from a private 16-bit baud divider.
// - Port enable gates both transmit start and receive storage.
// - Stop select set gives two stop bits, clear gives one.
// - Word length codes 00..11 select 5..8 data bits, parity extra.
// - Break bit holds the serial output low until cleared.
// - Parity enable bit writes enable; same bit reads head parity error.
// - Sticky parity sends the parity bit as constant one.
// - FIFO register upper nibble reads RX byte count.
// - FIFO register lower nibble reads TX byte count.
// - RX available when RX count exceeds write-only RX threshold.
// - TX ready when TX count is below write-only TX threshold.
// - Divider low twelve bits zero with port disabled empties FIFOs.
// - That clear also drops RX overflow, underflow and TX overflow.
// - That clear also zeroes the LIN timing counter.
// - Data read pops RX FIFO; data write pushes TX FIFO.
// - Idle line past threshold times 16 bits flags leftover RX bytes.
// - TX done sets when the last stop bit ends with the queue empty; software writes zero.
// - RX overflow sets on arrival into full FIFO; cleared by zero.
//
// The plain strobed port is this design's own decision.
`timescale 1ns/1ps

module fu_uart (
	input  wire logic           clk_sys,
	input  wire logic           reset,
	input  wire fu_pkg::fu_bus_t busReq,
	output logic [7:0]          rdata,
	input  wire logic           serialIn,
	output logic                serialOut
);

	fu_pkg::fu_state_t q;
	fu_pkg::fu_state_t n;

	logic       fifoClr;
	logic       tick;
	logic [2:0] lastBit;
	logic [7:0] wordMask;
	logic       txPush;
	logic       txPop;
	logic       rxPush;
	logic       rxPop;
	logic       rxAvail;
	logic       txReady;
	logic       wrStat;

	// ==========================================================
	// Derived conditions
	assign fifoClr  = (q.baud[11:0] == 12'h000) &&
		!q.cfg[fu_pkg::CFG_EN];
	assign tick     = (q.baudCnt == 16'h0000);
	assign lastBit  = fu_pkg::BITS_MIN +
		{1'b0, q.cfg[fu_pkg::CFG_WLS +: 2]};
	assign wordMask = 8'hFF >> (2'd3 - q.cfg[fu_pkg::CFG_WLS +: 2]);
	assign rxAvail  = (q.rxCnt > q.rxThr) || q.rdaIdle;
	assign txReady  = (q.txCnt < q.txThr);
	assign wrStat   = busReq.wr && busReq.addr == fu_pkg::ADDR_STAT;
	assign rdata     = q.rdata;
	assign serialOut = q.txd;

	// ==========================================================
	// Next state
	always_comb begin
		n = q;
		n.rdata = 8'h00;
		txPush = 1'b0;
		txPop  = 1'b0;
		rxPush = 1'b0;
		rxPop  = 1'b0;

		// Baud tick, reload from divider
		n.baudCnt = tick ? q.baud : q.baudCnt - 16'h0001;

		// Register writes
		if (busReq.wr) begin
			case (busReq.addr)
				fu_pkg::ADDR_CFG:     n.cfg = busReq.wdata;
				fu_pkg::ADDR_BAUD_LO: n.baud[7:0] = busReq.wdata;
				fu_pkg::ADDR_BAUD_HI: n.baud[15:8] = busReq.wdata;
				fu_pkg::ADDR_FIFO: begin
					n.rxThr = busReq.wdata[7:4];
					n.txThr = busReq.wdata[3:0];
				end
				fu_pkg::ADDR_DATA: begin
					if (q.txCnt == fu_pkg::FIFO_FULL)
						n.tx_overflow_flag = 1'b1;
					else
						txPush = !fifoClr;
				end
				default: ;
			endcase
		end

		// Register reads, answered next cycle
		if (busReq.rd) begin
			case (busReq.addr)
				fu_pkg::ADDR_CFG: begin
					n.rdata = q.cfg;
					n.rdata[fu_pkg::CFG_PE] = (q.rxCnt != 4'h0) &&
						q.rxMem[q.rxRd][8];
				end
				fu_pkg::ADDR_FIFO:
					n.rdata = {q.rxCnt, q.txCnt};
				fu_pkg::ADDR_BAUD_LO: n.rdata = q.baud[7:0];
				fu_pkg::ADDR_BAUD_HI: n.rdata = q.baud[15:8];
				fu_pkg::ADDR_STAT: begin
					n.rdata[fu_pkg::ST_TRA]  = txReady;
					n.rdata[fu_pkg::ST_RDA]  = rxAvail;
					n.rdata[fu_pkg::ST_RFO]  = q.rx_overflow_flag;
					n.rdata[fu_pkg::ST_RFU]  = q.rx_underflow_flag;
					n.rdata[fu_pkg::ST_TFO]  = q.tx_overflow_flag;
					n.rdata[fu_pkg::ST_FERR] = q.ferr;
					n.rdata[fu_pkg::ST_TI]   = q.ti;
				end
				fu_pkg::ADDR_DATA: begin
					n.rdata = q.rxMem[q.rxRd][7:0];
					if (q.rxCnt == 4'h0)
						n.rx_underflow_flag = 1'b1;
					else
						rxPop = !fifoClr;
				end
				default: ;
			endcase
		end

		// Software clears flags by writing zero; a set below wins
		if (wrStat) begin
			n.rx_overflow_flag  = n.rx_overflow_flag & busReq.wdata[fu_pkg::ST_RFO];
			n.rx_underflow_flag  = n.rx_underflow_flag & busReq.wdata[fu_pkg::ST_RFU];
			n.tx_overflow_flag  = n.tx_overflow_flag & busReq.wdata[fu_pkg::ST_TFO];
			n.ferr = q.ferr & busReq.wdata[fu_pkg::ST_FERR];
			n.ti   = q.ti & busReq.wdata[fu_pkg::ST_TI];
			if (q.rxCnt < q.rxThr)
				n.rdaIdle = q.rdaIdle &
					busReq.wdata[fu_pkg::ST_RDA];
		end

		// Transmitter, one bit per sixteen ticks
		if (tick && q.txSt != fu_pkg::SER_IDLE)
			n.txSub = q.txSub + 4'h1;
		if (tick) begin
			case (q.txSt)
				fu_pkg::SER_IDLE: begin
					if (q.cfg[fu_pkg::CFG_EN] && q.txCnt != 4'h0) begin
						n.txShift = q.txMem[q.txRd];
						txPop = 1'b1;
						n.txSub = 4'h0;
						n.txSt = fu_pkg::SER_START;
					end
				end
				fu_pkg::SER_START: begin
					if (q.txSub == fu_pkg::SUB_LAST) begin
						n.txBit = 3'h0;
						n.txSt = fu_pkg::SER_DATA;
					end
				end
				fu_pkg::SER_DATA: begin
					if (q.txSub == fu_pkg::SUB_LAST) begin
						n.txBit = q.txBit + 3'h1;
						n.txStop2 = 1'b0;
						if (q.txBit == lastBit)
							n.txSt = q.cfg[fu_pkg::CFG_PE] ?
								fu_pkg::SER_PAR : fu_pkg::SER_STOP;
					end
				end
				fu_pkg::SER_PAR: begin
					if (q.txSub == fu_pkg::SUB_LAST)
						n.txSt = fu_pkg::SER_STOP;
				end
				fu_pkg::SER_STOP: begin
					if (q.txSub == fu_pkg::SUB_LAST) begin
						if (q.cfg[fu_pkg::CFG_SB] && !q.txStop2)
							n.txStop2 = 1'b1;
						else begin
							n.txSt = fu_pkg::SER_IDLE;
							if (q.txCnt == 4'h0 && !txPush)
								n.ti = 1'b1;
						end
					end
				end
				default: n.txSt = fu_pkg::SER_IDLE;
			endcase
		end

		// Line level, registered so the pin never glitches
		case (q.txSt)
			fu_pkg::SER_START: n.txd = 1'b0;
			fu_pkg::SER_DATA:  n.txd = q.txShift[q.txBit];
			fu_pkg::SER_PAR:   n.txd = q.cfg[fu_pkg::CFG_SP] ? 1'b1 :
				(^(q.txShift & wordMask)) ^ q.cfg[fu_pkg::CFG_OP];
			default:           n.txd = 1'b1;
		endcase
		if (q.cfg[fu_pkg::CFG_BRK])
			n.txd = 1'b0;

		// Receiver, samples at mid bit
		if (tick) begin
			n.rxSub = q.rxSub + 4'h1;
			case (q.rxSt)
				fu_pkg::SER_IDLE: begin
					if (!serialIn) begin
						n.rxSub = 4'h0;
						n.rxShift = 8'h00;
						n.rxPerr = 1'b0;
						n.rxSt = fu_pkg::SER_START;
					end
				end
				fu_pkg::SER_START: begin
					if (q.rxSub == fu_pkg::SUB_MID) begin
						n.rxSub = 4'h0;
						n.rxBit = 3'h0;
						// A short glitch is not a start bit
						n.rxSt = serialIn ? fu_pkg::SER_IDLE :
							fu_pkg::SER_DATA;
					end
				end
				fu_pkg::SER_DATA: begin
					if (q.rxSub == fu_pkg::SUB_LAST) begin
						n.rxShift[q.rxBit] = serialIn;
						n.rxBit = q.rxBit + 3'h1;
						if (q.rxBit == lastBit)
							n.rxSt = q.cfg[fu_pkg::CFG_PE] ?
								fu_pkg::SER_PAR : fu_pkg::SER_STOP;
					end
				end
				fu_pkg::SER_PAR: begin
					if (q.rxSub == fu_pkg::SUB_LAST) begin
						n.rxPerr = serialIn != (q.cfg[fu_pkg::CFG_SP] |
							((^q.rxShift) ^ q.cfg[fu_pkg::CFG_OP]));
						n.rxSt = fu_pkg::SER_STOP;
					end
				end
				fu_pkg::SER_STOP: begin
					// One stop bit is checked even when two are sent
					if (q.rxSub == fu_pkg::SUB_LAST) begin
						n.rxSt = fu_pkg::SER_IDLE;
						if (!serialIn)
							n.ferr = 1'b1;
						if (q.cfg[fu_pkg::CFG_EN]) begin
							if (q.rxCnt == fu_pkg::FIFO_FULL && !rxPop)
								n.rx_overflow_flag = 1'b1;
							else
								rxPush = 1'b1;
						end
					end
				end
				default: n.rxSt = fu_pkg::SER_IDLE;
			endcase
		end

		// Idle timer counts whole bit periods of high idle line
		if (q.rxSt != fu_pkg::SER_IDLE || !serialIn) begin
			n.idleSub = 4'h0;
			n.linCnt = 16'h0000;
		end else if (tick) begin
			n.idleSub = q.idleSub + 4'h1;
			if (q.idleSub == fu_pkg::SUB_LAST &&
				q.linCnt != 16'hFFFF)
				n.linCnt = q.linCnt + 16'h0001;
		end
		if (q.rxCnt != 4'h0 && q.rxCnt < q.rxThr &&
			q.linCnt > {8'h00, q.rxThr, 4'h0})
			n.rdaIdle = 1'b1;

		// FIFO pointers and counts
		if (txPush) begin
			n.txMem[q.txWr] = busReq.wdata;
			n.txWr = (q.txWr == 4'hE) ? 4'h0 : q.txWr + 4'h1;
		end
		if (txPop)
			n.txRd = (q.txRd == 4'hE) ? 4'h0 : q.txRd + 4'h1;
		n.txCnt = q.txCnt + {3'h0, txPush} - {3'h0, txPop};
		if (rxPush) begin
			n.rxMem[q.rxWr] = {q.rxPerr, q.rxShift};
			n.rxWr = (q.rxWr == 4'hE) ? 4'h0 : q.rxWr + 4'h1;
		end
		if (rxPop)
			n.rxRd = (q.rxRd == 4'hE) ? 4'h0 : q.rxRd + 4'h1;
		n.rxCnt = q.rxCnt + {3'h0, rxPush} - {3'h0, rxPop};

		// FIFO clear: nothing can be stored while the clear condition holds
		if (fifoClr) begin
			n.txWr = 4'h0;
			n.txRd = 4'h0;
			n.txCnt = 4'h0;
			n.rxWr = 4'h0;
			n.rxRd = 4'h0;
			n.rxCnt = 4'h0;
			n.rx_overflow_flag = 1'b0;
			n.rx_underflow_flag = 1'b0;
			n.tx_overflow_flag = 1'b0;
			n.linCnt = 16'h0000;
		end
	end

	// ==========================================================
	// State register
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			q <= '0;
			q.cfg <= fu_pkg::CFG_RST;
			q.rxThr <= fu_pkg::THR_RST;
			q.txThr <= fu_pkg::THR_RST;
			q.baud <= fu_pkg::BAUD_RST;
			q.txSt <= fu_pkg::SER_IDLE;
			q.rxSt <= fu_pkg::SER_IDLE;
			q.txd <= 1'b1;
		end else begin
			q <= n;
		end
	end

	// ==========================================================
	// Checks
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (reset);

	break_low_a: assert property (q.cfg[fu_pkg::CFG_BRK] |=> !serialOut)
		else $error("break not driving line low");
	start_low_a: assert property (q.txSt == fu_pkg::SER_START &&
		!q.cfg[fu_pkg::CFG_BRK] |=> !serialOut)
		else $error("start bit not low");
	sticky_par_a: assert property (q.txSt == fu_pkg::SER_PAR &&
		q.cfg[fu_pkg::CFG_SP] && !q.cfg[fu_pkg::CFG_BRK] |=> serialOut)
		else $error("sticky parity bit not one");
	level_read_a: assert property (busReq.rd &&
		busReq.addr == fu_pkg::ADDR_FIFO |=>
		rdata == {$past(q.rxCnt), $past(q.txCnt)})
		else $error("FIFO level read wrong");
	fifo_clear_a: assert property (fifoClr |=> q.txCnt == 4'h0 &&
		q.rxCnt == 4'h0 && !q.rx_overflow_flag && !q.rx_underflow_flag && !q.tx_overflow_flag)
		else $error("FIFO clear incomplete");
	lin_clear_a: assert property (fifoClr |=> q.linCnt == 16'h0000)
		else $error("LIN counter not cleared");
	tx_hold_a: assert property (!q.cfg[fu_pkg::CFG_EN] &&
		q.txSt == fu_pkg::SER_IDLE |=> q.txSt == fu_pkg::SER_IDLE)
		else $error("transmit started while disabled");
	tx_push_a: assert property (busReq.wr && busReq.addr ==
		fu_pkg::ADDR_DATA && !fifoClr && q.txCnt < 4'hE &&
		!(tick && q.txSt == fu_pkg::SER_IDLE && q.cfg[fu_pkg::CFG_EN]) |=>
		q.txCnt == $past(q.txCnt) + 4'h1)
		else $error("data write did not push");
	tx_ready_a: assert property (busReq.rd && busReq.addr ==
		fu_pkg::ADDR_STAT |=> rdata[fu_pkg::ST_TRA] ==
		($past(q.txCnt) < $past(q.txThr)))
		else $error("TX ready flag wrong");
	rx_ovf_a: assert property (rxPush == 1'b0 && tick &&
		q.rxSt == fu_pkg::SER_STOP && q.rxSub == fu_pkg::SUB_LAST &&
		q.cfg[fu_pkg::CFG_EN] && q.rxCnt == fu_pkg::FIFO_FULL |=> q.rx_overflow_flag)
		else $error("RX overflow not flagged");

endmodule // fu_uart

// ---- fu_pkg.sv ----
// Constants and types shared by the FIFO serial port.
// Assumes an 8-bit register port and a single system clock.
package fu_pkg;

	// ==========================================================
	// Register map
	localparam logic [7:0] ADDR_BAUD_LO = 8'hA3;
	localparam logic [7:0] ADDR_BAUD_HI = 8'hA4;
	localparam logic [7:0] ADDR_FIFO    = 8'hA5;
	localparam logic [7:0] ADDR_DATA    = 8'hA6;
	localparam logic [7:0] ADDR_STAT    = 8'hA7;
	localparam logic [7:0] ADDR_CFG     = 8'hC2;

	// ==========================================================
	// Field positions
	localparam int CFG_EN  = 7;
	localparam int CFG_SB  = 6;
	localparam int CFG_WLS = 4;
	localparam int CFG_BRK = 3;
	localparam int CFG_OP  = 2;
	localparam int CFG_PE  = 1;
	localparam int CFG_SP  = 0;
	localparam int ST_TRA  = 6;
	localparam int ST_RDA  = 5;
	localparam int ST_RFO  = 4;
	localparam int ST_RFU  = 3;
	localparam int ST_TFO  = 2;
	localparam int ST_FERR = 1;
	localparam int ST_TI   = 0;
	localparam int FIFO_RX_LSB = 4;

	// ==========================================================
	// Reset values and counts
	localparam logic [7:0]  CFG_RST   = 8'h00;
	localparam logic [3:0]  THR_RST   = 4'h0;
	localparam logic [15:0] BAUD_RST  = 16'h0000;
	localparam logic [3:0]  FIFO_FULL = 4'hF;
	localparam logic [3:0]  SUB_LAST  = 4'hF;
	localparam logic [3:0]  SUB_MID   = 4'h7;
	localparam logic [2:0]  BITS_MIN  = 3'h4;

	// ==========================================================
	// Types
	typedef enum logic [2:0] {
		SER_IDLE, SER_START, SER_DATA, SER_PAR, SER_STOP
	} fu_ser_t;

	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wdata;
		logic       wr;
		logic       rd;
	} fu_bus_t;

	typedef struct packed {
		logic [7:0]        cfg;
		logic [3:0]        rxThr;
		logic [3:0]        txThr;
		logic [15:0]       baud;
		logic [7:0]        rdata;
		logic [14:0][7:0]  txMem;
		logic [3:0]        txWr;
		logic [3:0]        txRd;
		logic [3:0]        txCnt;
		logic [14:0][8:0]  rxMem;
		logic [3:0]        rxWr;
		logic [3:0]        rxRd;
		logic [3:0]        rxCnt;
		logic              rx_overflow_flag;
		logic              rx_underflow_flag;
		logic              tx_overflow_flag;
		logic              ferr;
		logic              ti;
		logic              rdaIdle;
		logic [15:0]       baudCnt;
		fu_ser_t           txSt;
		logic [3:0]        txSub;
		logic [2:0]        txBit;
		logic              txStop2;
		logic [7:0]        txShift;
		logic              txd;
		fu_ser_t           rxSt;
		logic [3:0]        rxSub;
		logic [2:0]        rxBit;
		logic [7:0]        rxShift;
		logic              rxPerr;
		logic [3:0]        idleSub;
		logic [15:0]       linCnt;
	} fu_state_t;

endpackage

// ---- fu_remote.sv ----
// Remote serial node on the far side of the port's line pins.
// Assumes the bench sets cfg to the frame format in use.
`timescale 1ns/1ps

module fu_remote #(
	parameter int BIT = 32
) (
	input  wire logic       clk_sys,
	input  wire logic [7:0] cfg,
	input  wire logic       txLine,
	output logic            rxLine,
	input  wire logic       sendGo,
	input  wire logic [7:0] sendByte,
	input  wire logic       sendBad,
	output logic [7:0]      gotByte,
	output logic            gotPar,
	output logic            gotStop,
	output int              gotCount
);
	int         nb;
	logic [7:0] sd;
	logic [7:0] gd;
	logic       gp;
	logic       gs;

	assign nb = 5 + int'(cfg[5:4]);

	function automatic logic parOf(logic [7:0] x);
		if (cfg[0])
			return 1'b1;
		return cfg[2] ? ~^x : ^x;
	endfunction

	// ==========================================================
	// Sender; busy frames ignore further requests
	initial rxLine = 1'b1;
	initial gotCount = 0;
	always @(posedge clk_sys) if (sendGo) begin
		sd = sendByte & (8'hFF >> (8 - nb));
		rxLine <= 1'b0;
		repeat (BIT) @(posedge clk_sys);
		for (int i = 0; i < nb; i++) begin
			rxLine <= sd[i];
			repeat (BIT) @(posedge clk_sys);
		end
		if (cfg[1]) begin
			rxLine <= parOf(sd) ^ sendBad;
			repeat (BIT) @(posedge clk_sys);
		end
		// Bad flag without parity breaks the stop bit instead
		rxLine <= !(sendBad && !cfg[1]);
		repeat (cfg[6] ? 2 * BIT : BIT) @(posedge clk_sys);
		rxLine <= 1'b1;
	end

	// ==========================================================
	// Receiver; samples mid-bit, checks start and every stop
	always @(negedge txLine) begin
		repeat (BIT / 2) @(posedge clk_sys);
		gs = ~txLine;
		gd = 8'h00;
		gp = 1'b0;
		for (int i = 0; i < nb; i++) begin
			repeat (BIT) @(posedge clk_sys);
			gd[i] = txLine;
		end
		if (cfg[1]) begin
			repeat (BIT) @(posedge clk_sys);
			gp = txLine;
		end
		repeat (BIT) @(posedge clk_sys);
		gs = gs & txLine;
		if (cfg[6]) begin
			repeat (BIT) @(posedge clk_sys);
			gs = gs & txLine;
		end
		gotByte <= gd;
		gotPar <= gp;
		gotStop <= gs;
		gotCount <= gotCount + 1;
	end
endmodule // fu_remote

// ---- fu_uart_bench.sv ----
// Self-checking bench for the FIFO serial port.
// Assumes fu_remote on the line and a small divider for speed.
`timescale 1ns/1ps

module fu_uart_bench;
	localparam int DIV = 1;
	localparam int BIT = 16 * (DIV + 1);
	logic            clk_sys = 1'b0;
	logic            reset = 1'b1;
	fu_pkg::fu_bus_t busReq;
	logic [7:0]      rdata;
	logic            serialIn;
	logic            serialOut;
	logic [7:0]      cfgTb;
	logic            sendGo;
	logic [7:0]      sendByte;
	logic            sendBad;
	logic [7:0]      gotByte;
	logic            gotPar;
	logic            gotStop;
	int              gotCount;
	int              bad_count = 0;
	int              tests_run = 0;
	int              cycles = 0;
	int              n;
	logic [31:0]     seed = 32'hD3E75881;
	logic [7:0]      q[$];
	logic [7:0]      modes[5] = '{8'hB0, 8'h82, 8'hD6, 8'hA3, 8'hF6};
	logic [7:0]      v;
	logic [7:0]      d;
	logic [7:0]      c;

	fu_uart uut (.clk_sys(clk_sys), .reset(reset), .busReq(busReq),
		.rdata(rdata), .serialIn(serialIn), .serialOut(serialOut));
	fu_remote #(.BIT(BIT)) peer (.clk_sys(clk_sys), .cfg(cfgTb),
		.txLine(serialOut), .rxLine(serialIn), .sendGo(sendGo),
		.sendByte(sendByte), .sendBad(sendBad), .gotByte(gotByte),
		.gotPar(gotPar), .gotStop(gotStop), .gotCount(gotCount));

	always #4 clk_sys = ~clk_sys;
	always @(posedge clk_sys) begin
		cycles++;
		if (cycles == 40000) begin
			bad_count++;
			conclude();
		end
	end

	// ==========================================================
	// Helpers
	function automatic logic [7:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed[7:0];
	endfunction
	function automatic logic [7:0] msk(logic [7:0] m);
		return 8'hFF >> (3 - m[5:4]);
	endfunction
	function automatic logic parE(logic [7:0] m, logic [7:0] x);
		if (m[0])
			return 1'b1;
		return m[2] ? ~^(x & msk(m)) : ^(x & msk(m));
	endfunction
	task automatic conclude();
		$display("tests run %0d, mismatches %0d", tests_run, bad_count);
		if (bad_count == 0 && tests_run > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		tests_run++;
		if (got !== exp) begin
			bad_count++;
			$display("unexpected at %0t: got %h expected %h", $time, got,
				exp);
		end
	endtask
	task automatic busWr(input logic [7:0] a, input logic [7:0] x);
		@(posedge clk_sys);
		busReq <= {a, x, 2'b10};
		@(posedge clk_sys);
		busReq <= '0;
	endtask
	task automatic busRd(input logic [7:0] a, output logic [7:0] x);
		@(posedge clk_sys);
		busReq <= {a, 8'h00, 2'b01};
		@(posedge clk_sys);
		busReq <= '0;
		#1 x = rdata;
	endtask
	task automatic rdChk(input logic [7:0] a, input logic [7:0] e);
		logic [7:0] r;
		busRd(a, r);
		chk(r, e);
	endtask
	// Bounded poll; a miss counts as a mismatch
	task automatic poll(input logic [7:0] a, input logic [7:0] m,
		input logic [7:0] e);
		for (int k = 0; k < 400; k++) begin
			busRd(a, v);
			if ((v & m) === e)
				break;
		end
		chk(v & m, e);
	endtask
	// Partner drops requests while busy, so let its last stop end
	task automatic send(input logic [7:0] x, input logic b);
		repeat (2 * BIT) @(posedge clk_sys);
		sendByte <= x;
		sendBad <= b;
		sendGo <= 1'b1;
		@(posedge clk_sys);
		sendGo <= 1'b0;
	endtask

	// ==========================================================
	// Main sequence
	initial begin
		busReq = '0;
		cfgTb = 8'h00;
		sendGo = 1'b0;
		sendByte = 8'h00;
		sendBad = 1'b0;
		repeat (8) @(posedge clk_sys);
		reset <= 1'b0;
		rdChk(fu_pkg::ADDR_CFG, fu_pkg::CFG_RST);
		rdChk(fu_pkg::ADDR_FIFO, 8'h00);
		rdChk(fu_pkg::ADDR_STAT, 8'h00);
		rdChk(8'h10, 8'h00);
		chk({7'h00, serialOut}, 8'h01);
		$display("test reset done");
		busWr(fu_pkg::ADDR_BAUD_LO, 8'(DIV));
		busWr(fu_pkg::ADDR_BAUD_HI, 8'h00);
		rdChk(fu_pkg::ADDR_BAUD_LO, 8'(DIV));
		busWr(fu_pkg::ADDR_FIFO, 8'h4F);
		for (int i = 0; i < 16; i++) begin
			busWr(fu_pkg::ADDR_DATA, rnd());
			n = (i < 15) ? i + 1 : 15;
			rdChk(fu_pkg::ADDR_FIFO, 8'(n));
			c = {1'b0, n < 15, 3'h0, i == 15, 2'h0};
			rdChk(fu_pkg::ADDR_STAT, c);
		end
		busWr(fu_pkg::ADDR_BAUD_LO, 8'h00);
		rdChk(fu_pkg::ADDR_FIFO, 8'h00);
		rdChk(fu_pkg::ADDR_STAT, 8'h40);
		busWr(fu_pkg::ADDR_BAUD_LO, 8'(DIV));
		busRd(fu_pkg::ADDR_DATA, v);
		rdChk(fu_pkg::ADDR_STAT, 8'h48);
		busWr(fu_pkg::ADDR_BAUD_LO, 8'h00);
		rdChk(fu_pkg::ADDR_STAT, 8'h40);
		busWr(fu_pkg::ADDR_BAUD_LO, 8'(DIV));
		$display("test fifo clear done");
		foreach (modes[i]) begin
			c = modes[i];
			cfgTb <= c;
			busWr(fu_pkg::ADDR_CFG, c);
			n = gotCount;
			for (int j = 0; j < 2; j++) begin
				d = rnd();
				q.push_back(d);
				busWr(fu_pkg::ADDR_DATA, d);
			end
			for (int j = 1; j <= 2; j++) begin
				for (int k = 0; k < 800 && gotCount < n + j; k++)
					@(posedge clk_sys);
				chk(8'(gotCount - n), 8'(j));
				d = q.pop_front();
				chk(gotByte, d & msk(c));
				chk({7'h00, gotPar}, {7'h00, c[1] & parE(c, d)});
				chk({7'h00, gotStop}, 8'h01);
			end
			poll(fu_pkg::ADDR_STAT, 8'h01, 8'h01);
			rdChk(fu_pkg::ADDR_STAT, 8'h41);
			busWr(fu_pkg::ADDR_STAT, 8'h00);
			rdChk(fu_pkg::ADDR_STAT, 8'h40);
			d = rnd();
			send(d, i[0]);
			poll(fu_pkg::ADDR_FIFO, 8'hF0, 8'h10);
			rdChk(fu_pkg::ADDR_CFG, {c[7:2], c[1] & i[0], c[0]});
			rdChk(fu_pkg::ADDR_DATA, d & msk(c));
		end
		$display("test frame modes done");
		c = 8'hB0;
		cfgTb <= c;
		busWr(fu_pkg::ADDR_CFG, c);
		for (int i = 0; i < 16; i++) begin
			d = rnd();
			if (i < 15)
				q.push_back(d);
			send(d, 1'b0);
			if (i < 15)
				poll(fu_pkg::ADDR_FIFO, 8'hF0, 8'((i + 1) * 16));
			else
				poll(fu_pkg::ADDR_STAT, 8'h10, 8'h10);
			c = {2'h1, i > 3, i == 15, 4'h0};
			rdChk(fu_pkg::ADDR_STAT, c);
		end
		busWr(fu_pkg::ADDR_STAT, 8'h00);
		rdChk(fu_pkg::ADDR_STAT, 8'h60);
		for (int i = 0; i < 15; i++) begin
			if (i == 12) begin
				rdChk(fu_pkg::ADDR_STAT, 8'h40);
				repeat (70 * BIT) @(posedge clk_sys);
				rdChk(fu_pkg::ADDR_STAT, 8'h60);
			end
			rdChk(fu_pkg::ADDR_DATA, q.pop_front());
		end
		rdChk(fu_pkg::ADDR_FIFO, 8'h00);
		$display("test receive fill done");
		// Low stop bit: flagged, byte still stored
		send(8'h5A, 1'b1);
		poll(fu_pkg::ADDR_STAT, 8'h02, 8'h02);
		rdChk(fu_pkg::ADDR_DATA, 8'h5A);
		busWr(fu_pkg::ADDR_STAT, 8'h00);
		rdChk(fu_pkg::ADDR_STAT, 8'h40);
		$display("test frame error done");
		busWr(fu_pkg::ADDR_CFG, 8'h08);
		for (int i = 0; i < 3; i++) begin
			repeat (BIT) @(posedge clk_sys);
			chk({7'h00, serialOut}, 8'h00);
		end
		busWr(fu_pkg::ADDR_CFG, 8'h00);
		repeat (2) @(posedge clk_sys);
		chk({7'h00, serialOut}, 8'h01);
		$display("test break done");
		conclude();
	end
endmodule // fu_uart_bench
